// ### rtl/srs_defines.vh
/*
 Constants of the speed reference shaper: timing counts, key hold times,
 soft start mode field positions and codes, auto-zero averaging depth.
 Assumes inclusion by bare name from the shaper's design files.
*/
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SRS_CLK_NS 5
`define SRS_MS_NS 1000000
`define SRS_MS_CYCLES ((`SRS_MS_NS) / (`SRS_CLK_NS))
`define SRS_HOLD_MS 1000
`define SRS_FLASH_MS 250
`define SRS_RAMP_RPM 1000

// ----------------------------------------------------------------------
// Soft start mode word, one hex digit per field
// ----------------------------------------------------------------------
`define SRS_PROF_POS 0
`define SRS_ORDER_POS 1
`define SRS_RATIO_POS 2
`define SRS_PROF_TRAP 4'h0
`define SRS_PROF_SCURVE 4'h1
`define SRS_PROF_FILT 4'h2
`define SRS_ORDER_FIRST 4'h0

// ----------------------------------------------------------------------
// Auto-zero and lag filters
// ----------------------------------------------------------------------
`define SRS_ZERO_SHIFT 4
`define SRS_LAG_FB 16
`define SRS_LAG_SH 8

`endif

// ### rtl/srs_lag.v
/*
 First-order lag stage: output approaches the input with a time
 constant given in milliseconds; zero time constant passes through.
 Assumes a free-running mclk and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "srs_defines.vh"

module srs_lag #(
    parameter W = 16,
    parameter MS_CYCLES = `SRS_MS_CYCLES
) (
    input wire mclk,
    input wire srst,
    input wire signed [W-1:0] x,
    input wire [13:0] tau_ms,
    output wire signed [W-1:0] y
);

localparam FB = `SRS_LAG_FB;
localparam SH = `SRS_LAG_SH;
localparam [31:0] MSC = MS_CYCLES;

reg signed [W+FB-1:0] acc_q;
reg [31:0] cnt_q;
wire [63:0] span;
wire [63:0] span_sh;
wire [31:0] interval;
wire signed [W+FB:0] diff;
wire signed [W+FB:0] step;
wire signed [W+FB:0] acc_n;

// ----------------------------------------------------------------------
// Update interval is tau / 2^SH, so 2^SH updates make one time constant
// ----------------------------------------------------------------------
assign span = {50'h0, tau_ms} * {32'h0, MSC};
assign span_sh = span >> SH;
assign interval = span_sh[31:0];
assign diff = {x[W-1], x, {FB{1'b0}}} - {acc_q[W+FB-1], acc_q};
assign step = diff >>> SH;
assign acc_n = {acc_q[W+FB-1], acc_q} + step;
assign y = acc_q[W+FB-1:FB];

always @(posedge mclk)
begin
    if (srst)
    begin
        acc_q <= {(W+FB){1'b0}};
        cnt_q <= 32'h0;
    end
    else if (tau_ms == 14'h0)
    begin
        acc_q <= {x, {FB{1'b0}}};
        cnt_q <= 32'h0;
    end
    else if (cnt_q + 32'h1 >= interval)
    begin
        acc_q <= acc_n[W+FB-1:0];
        cnt_q <= 32'h0;
    end
    else
    begin
        cnt_q <= cnt_q + 32'h1;
    end
end

endmodule // srs_lag

// ### rtl/srs_top.v
/*
 Speed reference shaper: offset removal (automatic zeroing and manual
 editing from the panel keys) and soft start shaping of the reference.
 Assumes keys and samples synchronous to mclk; key inputs are levels.
*/
`timescale 1ns/1ps
`include "srs_defines.vh"

// Overview of operation
// - Auto-zero measures input offset at 0 V and compensates by it.
// - Auto-zero result is kept and is editable in manual offset editing.
// - Flashing done shown while zeroing, then back to offset screen.
// - Editing entered after set held one second; shows current offset.
// - Up and down keys step the edited offset while editing.
// - Offset saved on one-second set hold; short press returns to function.
// - Soft start turns a reference step into bounded acceleration.
// - Mode low digit: 0 trapezoid, 1 S-curve, 2 filter.
// - Acceleration time is milliseconds from standstill to 1000 r/min.
// - Deceleration time is milliseconds from 1000 r/min to standstill.
// - Zero soft start times pass the reference through unchanged.
// - Mode third digit sets S-curve rounding, 0 near-linear to 3 high.
// - S-curve rise time sets the rounded corner duration.
// - Mode second digit: 0 first-order filter, 1 second-order filter.
// - After one filter time constant 36.8 percent of a step remains in first order.
module srs_top #(
    parameter W = 16,
    parameter MS_CYCLES = `SRS_MS_CYCLES
) (
    input wire mclk,
    input wire srst,
    input wire signed [W-1:0] ref_sample,
    input wire sample_valid,
    input wire fn_manual_sel,
    input wire key_mode,
    input wire key_set,
    input wire key_up,
    input wire key_down,
    input wire [15:0] soft_mode,
    input wire [13:0] accel_ms,
    input wire [13:0] decel_ms,
    input wire [13:0] scurve_ms,
    input wire [13:0] filter_ms,
    output reg signed [W-1:0] speed_ref_q,
    output reg signed [W-1:0] offset_q,
    output reg signed [W-1:0] edit_val_q,
    output reg [2:0] screen_q,
    output reg zero_busy_q,
    output reg done_flash_q
);

localparam [2:0] S_FUNC = 3'h0;
localparam [2:0] S_AUTO = 3'h1;
localparam [2:0] S_ZERO = 3'h2;
localparam [2:0] S_MANUAL = 3'h3;
localparam [2:0] S_EDIT = 3'h4;
localparam ZS = `SRS_ZERO_SHIFT;
localparam [31:0] MSC = MS_CYCLES;
localparam [31:0] RPM = `SRS_RAMP_RPM;
localparam [10:0] HOLD = `SRS_HOLD_MS;
localparam [8:0] FLASH = `SRS_FLASH_MS;
localparam signed [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
localparam signed [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};

function [3:0] digit;
    input [15:0] word;
    input integer pos;
    begin
        digit = word[pos*4 +: 4];
    end
endfunction

// ----------------------------------------------------------------------
// Key edges and set-key hold timing
// ----------------------------------------------------------------------
reg set_d_q, up_d_q, dn_d_q, mode_d_q;
reg [31:0] hold_cyc_q;
reg [10:0] hold_ms_q;
reg [31:0] fl_cyc_q;
reg [8:0] fl_ms_q;
wire set_rise = key_set & ~set_d_q;
wire set_fall = ~key_set & set_d_q;
wire up_rise = key_up & ~up_d_q;
wire dn_rise = key_down & ~dn_d_q;
wire mode_rise = key_mode & ~mode_d_q;
wire long_press = (hold_ms_q >= HOLD);

always @(posedge mclk)
begin
    if (srst)
    begin
        set_d_q <= 1'b0;
        up_d_q <= 1'b0;
        dn_d_q <= 1'b0;
        mode_d_q <= 1'b0;
        hold_cyc_q <= 32'h0;
        hold_ms_q <= 11'h0;
    end
    else
    begin
        set_d_q <= key_set;
        up_d_q <= key_up;
        dn_d_q <= key_down;
        mode_d_q <= key_mode;
        // Timer restarts at press, so a long press is a true full second
        if (set_rise)
        begin
            hold_cyc_q <= 32'h0;
            hold_ms_q <= 11'h0;
        end
        else if (key_set && !long_press)
        begin
            if (hold_cyc_q + 32'h1 >= MSC)
            begin
                hold_cyc_q <= 32'h0;
                hold_ms_q <= hold_ms_q + 11'h1;
            end
            else
            begin
                hold_cyc_q <= hold_cyc_q + 32'h1;
            end
        end
    end
end

// ----------------------------------------------------------------------
// Panel screens, auto-zero and offset editing
// ----------------------------------------------------------------------
reg [ZS:0] zcnt_q;
reg signed [W+ZS-1:0] zsum_q;
wire signed [W+ZS-1:0] zsum_n = zsum_q + {{ZS{ref_sample[W-1]}}, ref_sample};

always @(posedge mclk)
begin
    if (srst)
    begin
        screen_q <= S_FUNC;
        offset_q <= {W{1'b0}};
        edit_val_q <= {W{1'b0}};
        zero_busy_q <= 1'b0;
        done_flash_q <= 1'b0;
        zcnt_q <= {(ZS+1){1'b0}};
        zsum_q <= {(W+ZS){1'b0}};
        fl_cyc_q <= 32'h0;
        fl_ms_q <= 9'h0;
    end
    else
    begin
        case (screen_q)
            S_FUNC:
            begin
                if (set_fall)
                    screen_q <= fn_manual_sel ? S_MANUAL : S_AUTO;
            end
            S_AUTO:
            begin
                if (mode_rise)
                begin
                    screen_q <= S_ZERO;
                    zero_busy_q <= 1'b1;
                    done_flash_q <= 1'b1;
                    zcnt_q <= {(ZS+1){1'b0}};
                    zsum_q <= {(W+ZS){1'b0}};
                    fl_cyc_q <= 32'h0;
                    fl_ms_q <= 9'h0;
                end
                else if (set_fall)
                    screen_q <= S_FUNC;
            end
            S_ZERO:
            begin
                if (fl_cyc_q + 32'h1 >= MSC)
                begin
                    fl_cyc_q <= 32'h0;
                    if (fl_ms_q + 9'h1 >= FLASH)
                    begin
                        fl_ms_q <= 9'h0;
                        done_flash_q <= ~done_flash_q;
                    end
                    else
                        fl_ms_q <= fl_ms_q + 9'h1;
                end
                else
                    fl_cyc_q <= fl_cyc_q + 32'h1;
                if (zcnt_q[ZS])
                begin
                    offset_q <= zsum_q[W+ZS-1:ZS];
                    zero_busy_q <= 1'b0;
                    done_flash_q <= 1'b0;
                    screen_q <= S_AUTO;
                end
                else if (sample_valid)
                begin
                    zsum_q <= zsum_n;
                    zcnt_q <= zcnt_q + {{ZS{1'b0}}, 1'b1};
                end
            end
            S_MANUAL:
            begin
                if (set_fall)
                begin
                    if (long_press)
                    begin
                        edit_val_q <= offset_q;
                        screen_q <= S_EDIT;
                    end
                    else
                        screen_q <= S_FUNC;
                end
            end
            S_EDIT:
            begin
                if (set_fall)
                begin
                    if (long_press)
                    begin
                        offset_q <= edit_val_q;
                        screen_q <= S_MANUAL;
                    end
                    else
                        screen_q <= S_FUNC;
                end
                else if (up_rise && !dn_rise && edit_val_q != SMAX)
                    edit_val_q <= edit_val_q + {{(W-1){1'b0}}, 1'b1};
                else if (dn_rise && !up_rise && edit_val_q != SMIN)
                    edit_val_q <= edit_val_q - {{(W-1){1'b0}}, 1'b1};
            end
            default:
                screen_q <= S_FUNC;
        endcase
    end
end

// ----------------------------------------------------------------------
// Offset removal
// ----------------------------------------------------------------------
reg signed [W-1:0] ref_q;
wire signed [W:0] ref_diff = {ref_sample[W-1], ref_sample} - {offset_q[W-1], offset_q};

always @(posedge mclk)
begin
    if (srst)
        ref_q <= {W{1'b0}};
    else if (sample_valid)
    begin
        if (ref_diff[W] != ref_diff[W-1])
            ref_q <= ref_diff[W] ? SMIN : SMAX;
        else
            ref_q <= ref_diff[W-1:0];
    end
end

// ----------------------------------------------------------------------
// Trapezoid ramp: one r/min step each time the error crosses T * ms
// ----------------------------------------------------------------------
reg signed [W-1:0] ramp_q;
reg [31:0] err_q;
wire ramp_up = (ref_q > ramp_q);
wire accel = ramp_up ? (ramp_q >= 0) : (ramp_q <= 0);
wire [13:0] ramp_t = accel ? accel_ms : decel_ms;
wire [63:0] thr_w = {50'h0, ramp_t} * {32'h0, MSC};
wire [31:0] thr = thr_w[31:0];
wire [31:0] err_n = err_q + RPM;

always @(posedge mclk)
begin
    if (srst)
    begin
        ramp_q <= {W{1'b0}};
        err_q <= 32'h0;
    end
    else if (ramp_q == ref_q)
        err_q <= 32'h0;
    else if (ramp_t == 14'h0)
    begin
        ramp_q <= ref_q;
        err_q <= 32'h0;
    end
    // Slope of 1000 r/min per T
    else if (err_n >= thr)
    begin
        err_q <= err_n - thr;
        ramp_q <= ramp_up ? ramp_q + {{(W-1){1'b0}}, 1'b1}
                          : ramp_q - {{(W-1){1'b0}}, 1'b1};
    end
    else
        err_q <= err_n;
end

// ----------------------------------------------------------------------
// Rounding and filter stages
// ----------------------------------------------------------------------
// Ratio scales the rise time in quarters
wire [15:0] sc_prod = scurve_ms * digit(soft_mode, `SRS_RATIO_POS);
wire [13:0] sc_tau = sc_prod[15:2];
wire signed [W-1:0] scurve_y;
wire signed [W-1:0] filt1_y;
wire signed [W-1:0] filt2_y;

// Rounded corners from the rise time
srs_lag #(.W(W), .MS_CYCLES(MS_CYCLES)) u_round (
    .mclk(mclk),
    .srst(srst),
    .x(ramp_q),
    .tau_ms(sc_tau),
    .y(scurve_y)
);

srs_lag #(.W(W), .MS_CYCLES(MS_CYCLES)) u_filt1 (
    .mclk(mclk),
    .srst(srst),
    .x(ref_q),
    .tau_ms(filter_ms),
    .y(filt1_y)
);

// Second order is two equal lags in cascade
srs_lag #(.W(W), .MS_CYCLES(MS_CYCLES)) u_filt2 (
    .mclk(mclk),
    .srst(srst),
    .x(filt1_y),
    .tau_ms(filter_ms),
    .y(filt2_y)
);

// ----------------------------------------------------------------------
// Profile select
// ----------------------------------------------------------------------
always @(posedge mclk)
begin
    if (srst)
        speed_ref_q <= {W{1'b0}};
    else
    begin
        // Shaped reference out, profile by low digit
        case (digit(soft_mode, `SRS_PROF_POS))
            `SRS_PROF_TRAP: speed_ref_q <= ramp_q;
            `SRS_PROF_SCURVE: speed_ref_q <= scurve_y;
            `SRS_PROF_FILT: speed_ref_q <=
                (digit(soft_mode, `SRS_ORDER_POS) == `SRS_ORDER_FIRST) ? filt1_y : filt2_y;
            default: speed_ref_q <= ref_q;
        endcase
    end
end

endmodule // srs_top

// ### verif/srs_chk_assertions.sv
/*
 Port checker for srs_top: zeroing, offset editing, pass-through, ramp.
 Assumes it is bound to srs_top and sees mclk and srst there.
*/
`timescale 1ns/1ps
module srs_chk #(
    parameter W = 16,
    parameter MS_CYCLES = 200000
) (
    input wire mclk,
    input wire srst,
    input wire signed [W-1:0] ref_sample,
    input wire sample_valid,
    input wire key_mode,
    input wire key_up,
    input wire key_down,
    input wire [15:0] soft_mode,
    input wire [13:0] accel_ms,
    input wire [13:0] decel_ms,
    input wire signed [W-1:0] speed_ref_q,
    input wire signed [W-1:0] offset_q,
    input wire signed [W-1:0] edit_val_q,
    input wire [2:0] screen_q,
    input wire zero_busy_q,
    input wire done_flash_q
);
    localparam signed [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
    localparam signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    a_zero_start: assert property ($rose(key_mode) && screen_q == 3'h1
        |=> screen_q == 3'h2 && zero_busy_q && done_flash_q) else $error("zeroing start");
    a_busy_screen: assert property (zero_busy_q == (screen_q == 3'h2))
        else $error("busy and screen disagree");
    a_flash_busy: assert property (done_flash_q |-> zero_busy_q)
        else $error("flash outside zeroing");
    a_zero_bound: assert property ($rose(zero_busy_q) |-> ##[1:200] !zero_busy_q)
        else $error("zeroing too long");
    a_offset_cause: assert property (offset_q != $past(offset_q)
        |-> $past(zero_busy_q) || $past(screen_q) == 3'h4) else $error("offset moved");
    a_edit_entry: assert property (screen_q == 3'h4 && $past(screen_q) != 3'h4
        |-> edit_val_q == offset_q) else $error("edit not seeded");
    a_edit_up: assert property (screen_q == 3'h4 && $rose(key_up) && !key_down
        && edit_val_q != MAXV |=> edit_val_q == $past(edit_val_q) + 1) else $error("up");
    a_edit_down: assert property (screen_q == 3'h4 && $rose(key_down) && !key_up
        && edit_val_q != MINV |=> edit_val_q == $past(edit_val_q) - 1) else $error("down");
    a_pass_zero: assert property ((sample_valid && soft_mode[3:0] == 4'h0
        && accel_ms == 14'h0 && decel_ms == 14'h0 && $stable(ref_sample)
        && $stable(offset_q))[*5] |-> speed_ref_q == ref_sample - offset_q)
        else $error("no pass-through");
    a_ramp_slope: assert property (soft_mode[3:0] == 4'h0 && $past(soft_mode[3:0], 2) == 4'h0
        && accel_ms != 14'h0 && decel_ms != 14'h0 && $past(accel_ms, 2) != 14'h0
        && $past(decel_ms, 2) != 14'h0 |-> speed_ref_q <= $past(speed_ref_q) + 1
        && speed_ref_q >= $past(speed_ref_q) - 1) else $error("ramp too steep");
endmodule // srs_chk

bind srs_top srs_chk #(.W(W), .MS_CYCLES(MS_CYCLES)) srs_chk_i (.mclk, .srst, .ref_sample,
    .sample_valid, .key_mode, .key_up, .key_down, .soft_mode, .accel_ms, .decel_ms,
    .speed_ref_q, .offset_q, .edit_val_q, .screen_q, .zero_busy_q, .done_flash_q);

// ### verif/srs_ref_src.sv
/*
 Upstream reference controller model: converts the commanded level into
 samples, every cycle or every other cycle. Assumes the shaper's clock.
*/
`timescale 1ns/1ps
module srs_ref_src #(
    parameter W = 16
) (
    input wire mclk,
    input wire srst,
    input wire signed [W-1:0] level,
    input wire slow,
    output logic signed [W-1:0] ref_sample,
    output logic sample_valid
);
    logic gap_q;
    // bench-set level
    // Between samples the line carries junk, so a stale sample is never taken
    always @(posedge mclk)
    begin
        gap_q <= srst ? 1'b0 : slow & ~gap_q;
        sample_valid <= ~srst & ~gap_q;
        ref_sample <= (srst | gap_q) ? ~level : level;
    end
endmodule // srs_ref_src

// ### verif/tb_top.sv
/*
 Self-checking bench for srs_top: key sequences, zeroing, offset editing
 and soft start profiles. Assumes a shortened millisecond count.
*/
`timescale 1ns/1ps
module tb_top;
    localparam int MS = 20;
    localparam int LONG = 1000 * MS + 10;
    localparam logic signed [15:0] OFF = 16'sh0007;
    logic mclk, srst, sample_valid, fn_manual_sel, key_mode, key_set, key_up, key_down, slow;
    logic signed [15:0] ref_sample, level, speed_ref_q, offset_q, edit_val_q;
    logic [15:0] soft_mode;
    logic [13:0] accel_ms, decel_ms, scurve_ms, filter_ms;
    logic [2:0] screen_q;
    logic zero_busy_q, done_flash_q;
    int miscompares = 0;
    int checks_done = 0;
    int i;

    srs_ref_src srs_ref_src_i (.mclk, .srst, .level, .slow, .ref_sample, .sample_valid);
    srs_top #(.MS_CYCLES(MS)) srs_top_i (.mclk, .srst, .ref_sample, .sample_valid,
        .fn_manual_sel, .key_mode, .key_set, .key_up, .key_down, .soft_mode, .accel_ms,
        .decel_ms, .scurve_ms, .filter_ms, .speed_ref_q, .offset_q, .edit_val_q, .screen_q,
        .zero_busy_q, .done_flash_q);

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Wide enough that packed screen and value pairs are compared whole
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    end
    endtask

    task span(input logic signed [15:0] got, input logic signed [15:0] lo,
        input logic signed [15:0] hi);
    begin
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h..%h", $time, got, lo, hi);
        end
    end
    endtask

    // Key 0 set, 1 mode, 2 up, 3 down, held n cycles
    task press(input int k, input int n);
    begin
        @(negedge mclk);
        {key_set, key_mode, key_up, key_down} = 4'h8 >> k;
        repeat (n) @(negedge mclk);
        {key_set, key_mode, key_up, key_down} = 4'h0;
        repeat (3) @(negedge mclk);
    end
    endtask

    // Settle at zero with ramp and filter times zero, then apply a step of h and sample after n cycles
    task step_run(input logic [15:0] mode, input logic [13:0] t, input logic signed [15:0] h,
        input int n, input logic signed [15:0] lo, input logic signed [15:0] hi);
    begin
        @(negedge mclk);
        {accel_ms, decel_ms, filter_ms} = 42'h0;
        soft_mode = mode;
        level = OFF;
        repeat (10) @(negedge mclk);
        {accel_ms, decel_ms, filter_ms} = {t, t, t};
        level = h + OFF;
        repeat (n) @(negedge mclk);
        span(speed_ref_q, lo, hi);
    end
    endtask

    task print_verdict;
    begin
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog, sequence
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        // Tests need about 67k cycles, mostly the three one-second holds
        #450000;
        miscompares++;
        print_verdict;
    end

    initial
    begin
        {srst, slow, fn_manual_sel, key_mode, key_set, key_up, key_down} = 7'h60;
        {soft_mode, accel_ms, decel_ms, filter_ms} = 58'h0;
        scurve_ms = 14'h0028;
        level = OFF;
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        repeat (2) @(negedge mclk);
        chk(offset_q, 16'h0000);
        // Zeroing with the input at 0 V plus a converter offset
        press(0, 2);
        chk(screen_q, 16'h0001);
        key_mode = 1'b1;
        repeat (2) @(negedge mclk);
        chk({zero_busy_q, done_flash_q}, 16'h0003);
        key_mode = 1'b0;
        for (i = 0; i < 200 && zero_busy_q !== 1'b0; i++) @(negedge mclk);
        chk(offset_q, OFF);
        chk({screen_q, done_flash_q}, 16'h0002);
        press(0, 2);
        chk(screen_q, 16'h0000);
        slow = 1'b0;
        step_run(16'h0000, 14'h0, 16'sh0064, 8, 16'sh0064, 16'sh0064);
        step_run(16'h0003, 14'h0, 16'sh0032, 8, 16'sh0032, 16'sh0032);
        step_run(16'h0000, 14'h0064, 16'sh00c8, 200, 16'sh005f, 16'sh0065);
        repeat (300) @(negedge mclk);
        chk(speed_ref_q, 16'h00c8);
        decel_ms = 14'h00c8;
        level = OFF;
        repeat (400) @(negedge mclk);
        span(speed_ref_q, 16'sh005f, 16'sh0069);
        step_run(16'h0001, 14'h0064, 16'sh00c8, 200, 16'sh005f, 16'sh0065);
        for (i = 1; i < 4; i++)
            step_run({4'h0, i[3:0], 8'h01}, 14'h0064, 16'sh00c8, 200, 16'sh0001, 16'sh005e);
        step_run(16'h0002, 14'h0080, 16'sh03e8, 2563, 16'sh026c, 16'sh0285);
        step_run(16'h0012, 14'h0080, 16'sh03e8, 2563, 16'sh00fa, 16'sh0118);
        // Manual offset path, as used behind an outer position loop
        fn_manual_sel = 1'b1;
        press(0, 2);
        chk(screen_q, 16'h0003);
        press(0, LONG);
        chk({screen_q, edit_val_q}, {3'h4, OFF});
        for (i = 0; i < 4; i++)
            press(i < 3 ? 2 : 3, 2);
        chk(edit_val_q, 16'h0009);
        press(0, LONG);
        chk({screen_q, offset_q}, 19'h30009);
        press(0, LONG);
        press(2, 2);
        press(0, 2);
        chk({screen_q, offset_q}, 19'h00009);
        srst = 1'b1;
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        repeat (2) @(negedge mclk);
        chk({screen_q, offset_q}, 19'h0);
        print_verdict;
    end
endmodule // tb_top
